// ==== design/sdram_ctl_host.sv ====
// memory controller end: init sequence, low-power entry and exit, command spacing
`timescale 1ns/100ps
`include "sdram_defines.svh"
module sdram_ctl_host #(
	parameter int BURST_LEN = `BURST_LEN,
	parameter int PWRUP_CYC = `PWRUP_CYC
) (
	// clock and reset
	input logic clk,
	input logic rst_b,
	// command pins
	sdram_if.ctl lnk,
	// user requests
	input logic req_valid,
	input sdram_pkg::cmd_t req_cmd,
	input logic [1:0] req_ba,
	input logic req_ap,
	output logic req_ready,
	// low-power holds
	input logic pd_hold,
	input logic sr_hold,
	input logic dpd_hold,
	// status
	output logic init_done
);
	import sdram_pkg::*;
	localparam int WW = 14;

	ctl_t st_r, st_nxt;
	logic [WW-1:0] wt_r, wt_nxt;
	logic [1:0] refs_r, refs_nxt;
	cmd_t cmd_nxt;
	logic [3:0] pins_r, pins_nxt;
	logic cke_r, cke_nxt, a10_r, a10_nxt, ready_r, ready_nxt, done_r, done_nxt;
	logic [1:0] ba_r, ba_nxt;

	// spacing after a command, so the bank timers have run out; none after a read or write without autoprecharge
	function automatic logic [WW-1:0] gap(input cmd_t c, input logic ap);
		case (c)
			C_ACT: gap = WW'(`RCD_CYC);
			C_PRE: gap = WW'(`RP_CYC);
			C_REF: gap = WW'(`RC_CYC);
			C_LMR: gap = WW'(`MRD_CYC);
			C_RD, C_WR: gap = ap ? WW'(BURST_LEN + `RP_CYC) : '0;
			default: gap = '0;
		endcase
	endfunction : gap

	always_comb begin
		st_nxt = st_r;
		refs_nxt = refs_r;
		cmd_nxt = C_NOP;
		cke_nxt = 1'b1;
		ba_nxt = 2'h0;
		a10_nxt = 1'b0;
		wt_nxt = (wt_r != '0) ? wt_r - WW'(1) : wt_r;
		case (st_r)
			S_PWRUP: if (wt_r == '0) begin
				cmd_nxt = C_PRE;
				a10_nxt = 1'b1;
				wt_nxt = WW'(`RP_CYC);
				st_nxt = S_PALL;
			end
			S_PALL: if (wt_r == '0) begin
				cmd_nxt = C_REF;
				wt_nxt = WW'(`RC_CYC);
				refs_nxt = 2'h1;
				st_nxt = S_REF;
			end
			S_REF: if (wt_r == '0) begin
				if (refs_r < 2'(`MIN_REFS)) begin
					cmd_nxt = C_REF;
					wt_nxt = WW'(`RC_CYC);
					refs_nxt = refs_r + 2'h1;
				end else begin
					cmd_nxt = C_LMR;
					wt_nxt = WW'(`MRD_CYC);
					st_nxt = S_LMR;
				end
			end
			S_LMR: if (wt_r == '0) begin
				cmd_nxt = C_LMR;
				ba_nxt = 2'h2;
				wt_nxt = WW'(`MRD_CYC);
				st_nxt = S_EMR;
			end
			S_EMR: if (wt_r == '0) st_nxt = S_RUN;
			S_RUN: if (ready_r && req_valid) begin
				cmd_nxt = req_cmd;
				ba_nxt = req_ba;
				a10_nxt = req_ap;
				wt_nxt = gap(req_cmd, req_ap);
			end else if (wt_r == '0) begin
				if (dpd_hold) begin
					cke_nxt = 1'b0;
					cmd_nxt = C_BST;
					wt_nxt = WW'(`DPD_CYC);
					st_nxt = S_DPD;
				end else if (sr_hold) begin
					cke_nxt = 1'b0;
					cmd_nxt = C_REF;
					st_nxt = S_SR;
				end else if (pd_hold) begin
					cke_nxt = 1'b0;
					st_nxt = S_PD;
				end
			end
			S_PD: begin
				wt_nxt = wt_r;
				cke_nxt = !pd_hold;
				if (!pd_hold) st_nxt = S_RUN;
			end
			S_SR: begin
				cke_nxt = !sr_hold;
				if (!sr_hold) begin
					wt_nxt = WW'(`XSR_CYC);
					st_nxt = S_XSR;
				end
			end
			S_XSR: if (wt_r == '0) st_nxt = S_RUN;
			S_DPD: begin
				cke_nxt = 1'b0;
				if (!dpd_hold && wt_r == '0) begin
					cke_nxt = 1'b1;
					wt_nxt = WW'(PWRUP_CYC);
					st_nxt = S_PWRUP;
				end
			end
			default: st_nxt = S_PWRUP;
		endcase
		case (cmd_nxt)
			C_INH: pins_nxt = `ENC_INH;
			C_ACT: pins_nxt = `ENC_ACT;
			C_REF: pins_nxt = `ENC_REF;
			C_LMR: pins_nxt = `ENC_LMR;
			C_PRE: pins_nxt = `ENC_PRE;
			C_RD: pins_nxt = `ENC_RD;
			C_WR: pins_nxt = `ENC_WR;
			C_BST: pins_nxt = `ENC_BST;
			default: pins_nxt = `ENC_NOP;
		endcase
		ready_nxt = st_nxt == S_RUN && wt_nxt == '0 && !dpd_hold && !sr_hold && !pd_hold;
		done_nxt = !(st_nxt inside {S_PWRUP, S_PALL, S_REF, S_LMR, S_EMR, S_DPD});
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= S_PWRUP;
			wt_r <= WW'(PWRUP_CYC);
			refs_r <= 2'h0;
			pins_r <= `ENC_INH;
			cke_r <= 1'b1;
			ba_r <= 2'h0;
			a10_r <= 1'b0;
			ready_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			wt_r <= wt_nxt;
			refs_r <= refs_nxt;
			pins_r <= pins_nxt;
			cke_r <= cke_nxt;
			ba_r <= ba_nxt;
			a10_r <= a10_nxt;
			ready_r <= ready_nxt;
			done_r <= done_nxt;
		end
	end

	assign lnk.cke = cke_r;
	assign lnk.cs_n = pins_r[3];
	assign lnk.ras_n = pins_r[2];
	assign lnk.cas_n = pins_r[1];
	assign lnk.we_n = pins_r[0];
	assign lnk.ba = ba_r;
	assign lnk.a10 = a10_r;
	assign req_ready = ready_r;
	assign init_done = done_r;
endmodule : sdram_ctl_host

// ==== design/sdram_defines.svh ====
// timing figures, cycle counts and command pin codes of the memory link
`ifndef SDRAM_DEFINES_SVH
`define SDRAM_DEFINES_SVH
`define CLK_PERIOD_NS 25
`define T_RP_NS 20
`define T_RCD_NS 20
`define T_RC_NS 70
`define T_MRD_NS 20
`define T_XSR_NS 80
`define T_DPD_US 100
`define T_PWRUP_US 200
`define CYC_MIN(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RP_CYC `CYC_MIN(`T_RP_NS)
`define RCD_CYC `CYC_MIN(`T_RCD_NS)
`define RC_CYC `CYC_MIN(`T_RC_NS)
`define MRD_CYC `CYC_MIN(`T_MRD_NS)
`define XSR_CYC `CYC_MIN(`T_XSR_NS)
`define DPD_CYC `CYC_MIN(`T_DPD_US * 1000)
`define PWRUP_CYC `CYC_MIN(`T_PWRUP_US * 1000)
`define BURST_LEN 4
`define MIN_REFS 2
`define MIN_XSR_NOPS 2
// {cs_n, ras_n, cas_n, we_n}
`define ENC_INH 4'hF
`define ENC_NOP 4'h7
`define ENC_ACT 4'h3
`define ENC_REF 4'h1
`define ENC_LMR 4'h0
`define ENC_PRE 4'h2
`define ENC_RD 4'h5
`define ENC_WR 4'h4
`define ENC_BST 4'h6
`endif

// ==== design/sdram_if.sv ====
// command pins between memory controller and memory
`timescale 1ns/100ps
interface sdram_if;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [1:0] ba;
	logic a10;
	modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, a10);
	modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, a10);
endinterface : sdram_if

// ==== design/sdram_pkg.sv ====
// types of both ends of the memory link; only cmd_t is used by both
package sdram_pkg;
	typedef enum logic [3:0] {C_INH, C_NOP, C_ACT, C_REF, C_LMR, C_PRE, C_RD, C_WR, C_BST} cmd_t;
	typedef enum logic [2:0] {P_RUN = 3'h0, P_PDN = 3'h1, P_SUSP = 3'h3, P_SREF = 3'h2,
		P_XSR = 3'h6, P_DPD = 3'h7} pwr_t;
	typedef enum logic [2:0] {B_IDLE = 3'h0, B_ACTG = 3'h1, B_ACT = 3'h3, B_RD = 3'h2,
		B_WR = 3'h6, B_RDA = 3'h7, B_WRA = 3'h5, B_PRE = 3'h4} bank_t;
	typedef enum logic [1:0] {ST_PALL = 2'h0, ST_REF = 2'h1, ST_MODE = 2'h3,
		ST_DONE = 2'h2} stage_t;
	typedef enum logic [3:0] {S_PWRUP = 4'h0, S_PALL = 4'h1, S_REF = 4'h3, S_LMR = 4'h2,
		S_EMR = 4'h6, S_RUN = 4'h7, S_PD = 4'h5, S_SR = 4'h4, S_XSR = 4'hC,
		S_DPD = 4'hD} ctl_t;
endpackage : sdram_pkg

// ==== design/sdram_state_dev.sv ====
// memory end: clock-enable state machine, per-bank states, command checks
// How it works
// - terminate with clock enable low: deep sleep
// - deep sleep held at least 100 us; not checked here, left as soon as clock enable goes high
// - clock enable high leaves deep sleep; reinit
// - reinit: wait, precharge all, refreshes, modes; the wait is not checked here
// - power-down exit: back to run next edge
// - self refresh exit waits, only quiet commands
// - suspend exit: next command at next edge
// - clock enable falling picks the low-power state
// - strobe patterns decode into commands
// - deselect is inhibit; all strobes high nop
// - bank commands only with clock enable high
// - refresh and mode load need all idle
// - terminate ends latest burst, any bank
// - precharge of idle bank does nothing
// - idle after precharge time; active after delay
// - busy bank takes no same-bank command
// - global busy phases take only quiet commands
// - active bank takes read, write, precharge
// - reading bank takes read, write, precharge, terminate
// - writing bank takes read, write, precharge, terminate
// - other banks block only precharge all, which needs each bank idle, active, reading or writing
// - reads and writes with or without autoprecharge
`timescale 1ns/100ps
`include "sdram_defines.svh"
module sdram_state_dev #(
	parameter int NBANK = 4,
	parameter int BURST_LEN = `BURST_LEN
) (
	// clock and reset
	input logic clk,
	input logic rst_b,
	// command pins
	sdram_if.dev lnk,
	// state seen by the user side
	output sdram_pkg::pwr_t pwr_state,
	output sdram_pkg::bank_t [NBANK-1:0] bank_state,
	output logic all_idle,
	output logic need_init,
	output logic cmd_taken,
	output logic cmd_illegal
);
	import sdram_pkg::*;

	cmd_t cmd;
	logic quiet, gbusy, idle_all, in_burst, exec, bad, pa_ok;
	logic [1:0] tb;
	pwr_t pwr_r, pwr_nxt;
	stage_t stage_r, stage_nxt;
	logic [1:0] refs_r, refs_nxt, nops_r, nops_nxt, last_r, last_nxt;
	logic cke_prev_r;
	logic [7:0] gcnt_r, gcnt_nxt;
	bank_t [NBANK-1:0] bank_r, bank_nxt;
	logic [NBANK-1:0][7:0] bcnt_r, bcnt_nxt;
	logic all_idle_r, all_idle_nxt, need_init_r, need_init_nxt;
	logic taken_r, taken_nxt, bad_r;

	function automatic cmd_t decode(input logic [3:0] p);
		if (p[3]) return C_INH;
		case (p)
			`ENC_NOP: return C_NOP;
			`ENC_ACT: return C_ACT;
			`ENC_REF: return C_REF;
			`ENC_LMR: return C_LMR;
			`ENC_PRE: return C_PRE;
			`ENC_RD: return C_RD;
			`ENC_WR: return C_WR;
			`ENC_BST: return C_BST;
			default: return C_NOP;
		endcase
	endfunction : decode

	function automatic logic is_rw(input bank_t s);
		return s == B_RD || s == B_WR;
	endfunction : is_rw

	function automatic logic is_burst(input bank_t s);
		return is_rw(s) || s == B_RDA || s == B_WRA;
	endfunction : is_burst

	always_comb begin
		cmd = decode({lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n});
		quiet = cmd == C_INH || cmd == C_NOP;
		tb = lnk.ba;
		gbusy = gcnt_r != 8'h00;
		idle_all = !gbusy;
		in_burst = 1'b0;
		pa_ok = 1'b1;
		for (int b = 0; b < NBANK; b++) begin
			if (bank_r[b] != B_IDLE) idle_all = 1'b0;
			if (is_burst(bank_r[b])) in_burst = 1'b1;
			if (!(bank_r[b] inside {B_IDLE, B_ACT, B_RD, B_WR})) pa_ok = 1'b0;
		end
		pwr_nxt = pwr_r;
		stage_nxt = stage_r;
		refs_nxt = refs_r;
		nops_nxt = nops_r;
		last_nxt = last_r;
		gcnt_nxt = gbusy ? gcnt_r - 8'h01 : gcnt_r;
		bank_nxt = bank_r;
		bcnt_nxt = bcnt_r;
		exec = 1'b0;
		bad = 1'b0;
		// bank timers stand still while the internal clock is suspended
		if (pwr_r != P_SUSP) begin
			for (int b = 0; b < NBANK; b++) begin
				if (bcnt_r[b] != 8'h00) begin
					bcnt_nxt[b] = bcnt_r[b] - 8'h01;
					if (bcnt_r[b] == 8'h01) begin
						if (bank_r[b] inside {B_ACTG, B_RD, B_WR})
							bank_nxt[b] = B_ACT;
						else
							bank_nxt[b] = B_IDLE;
					end
				end
			end
		end
		case (pwr_r)
			P_RUN: begin
				if (cke_prev_r && !lnk.cke) begin
					if (cmd == C_BST)
						pwr_nxt = P_DPD;
					else if (in_burst)
						pwr_nxt = P_SUSP;
					else if (gbusy)
						bad = 1'b1;
					else if (quiet)
						pwr_nxt = P_PDN;
					else if (cmd == C_REF && idle_all)
						pwr_nxt = P_SREF;
					else
						bad = 1'b1;
				end else if (lnk.cke) begin
					exec = 1'b1;
				end
			end
			P_PDN: if (lnk.cke) begin
				pwr_nxt = P_RUN;
				if (!quiet) bad = 1'b1;
			end
			P_SUSP: if (lnk.cke) pwr_nxt = P_RUN;
			P_SREF: if (lnk.cke) begin
				if (!quiet) bad = 1'b1;
				pwr_nxt = P_XSR;
				gcnt_nxt = 8'(`XSR_CYC);
				nops_nxt = 2'h0;
			end
			P_XSR: begin
				if (!quiet) bad = 1'b1;
				if (cmd == C_NOP && nops_r != 2'h3) nops_nxt = nops_r + 2'h1;
				if (gcnt_r <= 8'h01) begin
					pwr_nxt = P_RUN;
					if (nops_nxt < 2'(`MIN_XSR_NOPS)) bad = 1'b1;
				end
			end
			P_DPD: if (lnk.cke) begin
				pwr_nxt = P_RUN;
				stage_nxt = ST_PALL;
				refs_nxt = 2'h0;
			end
			default: pwr_nxt = P_RUN;
		endcase
		if (exec && !quiet) begin
			if (gbusy) begin
				bad = 1'b1;
			end else begin
				case (cmd)
					C_ACT: begin
						if (need_init_r || bank_r[tb] != B_IDLE) begin
							bad = 1'b1;
						end else begin
							bank_nxt[tb] = B_ACTG;
							bcnt_nxt[tb] = 8'(`RCD_CYC);
						end
					end
					C_REF: begin
						if (!idle_all || (need_init_r && stage_r != ST_REF)) begin
							bad = 1'b1;
						end else begin
							gcnt_nxt = 8'(`RC_CYC);
							if (refs_r != 2'h3) refs_nxt = refs_r + 2'h1;
						end
					end
					C_LMR: begin
						if (!idle_all) begin
							bad = 1'b1;
						end else if (need_init_r && (stage_r == ST_PALL ||
							(stage_r == ST_REF && (refs_r < 2'(`MIN_REFS) || lnk.ba[1])) ||
							(stage_r == ST_MODE && !lnk.ba[1]))) begin
							bad = 1'b1;
						end else begin
							gcnt_nxt = 8'(`MRD_CYC);
							if (stage_r == ST_REF) stage_nxt = ST_MODE;
							else if (stage_r == ST_MODE) stage_nxt = ST_DONE;
						end
					end
					C_PRE: begin
						if (lnk.a10) begin
							if (!pa_ok) begin
								bad = 1'b1;
							end else begin
								gcnt_nxt = 8'(`RP_CYC);
								if (stage_r == ST_PALL) stage_nxt = ST_REF;
								for (int b = 0; b < NBANK; b++) begin
									if (bank_r[b] != B_IDLE) begin
										bank_nxt[b] = B_PRE;
										bcnt_nxt[b] = 8'(`RP_CYC);
									end
								end
							end
						end else if (bank_r[tb] inside {B_ACT, B_RD, B_WR}) begin
							bank_nxt[tb] = B_PRE;
							bcnt_nxt[tb] = 8'(`RP_CYC);
						end else if (bank_r[tb] != B_IDLE) begin
							bad = 1'b1;
						end
					end
					C_RD, C_WR: begin
						if (need_init_r || !(bank_r[tb] inside {B_ACT, B_RD, B_WR})) begin
							bad = 1'b1;
						end else begin
							// a new burst cuts off the bursts of the other banks
							for (int b = 0; b < NBANK; b++) begin
								if (2'(b) != tb && is_rw(bank_r[b])) begin
									bank_nxt[b] = B_ACT;
									bcnt_nxt[b] = 8'h00;
								end else if (2'(b) != tb && is_burst(bank_r[b])) begin
									bank_nxt[b] = B_PRE;
									bcnt_nxt[b] = 8'(`RP_CYC);
								end
							end
							if (lnk.a10) begin
								bank_nxt[tb] = (cmd == C_RD) ? B_RDA : B_WRA;
								bcnt_nxt[tb] = 8'(BURST_LEN + `RP_CYC);
							end else begin
								bank_nxt[tb] = (cmd == C_RD) ? B_RD : B_WR;
								bcnt_nxt[tb] = 8'(BURST_LEN);
							end
							last_nxt = tb;
						end
					end
					C_BST: begin
						if (is_rw(bank_r[last_r])) begin
							bank_nxt[last_r] = B_ACT;
							bcnt_nxt[last_r] = 8'h00;
						end else begin
							bad = 1'b1;
						end
					end
					default: bad = 1'b1;
				endcase
			end
		end
		all_idle_nxt = pwr_nxt == P_RUN && gcnt_nxt == 8'h00;
		for (int b = 0; b < NBANK; b++) begin
			if (bank_nxt[b] != B_IDLE) all_idle_nxt = 1'b0;
		end
		need_init_nxt = stage_nxt != ST_DONE;
		taken_nxt = exec && !quiet && !bad;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pwr_r <= P_RUN;
			stage_r <= ST_PALL;
			refs_r <= 2'h0;
			nops_r <= 2'h0;
			last_r <= 2'h0;
			cke_prev_r <= 1'b0;
			gcnt_r <= 8'h00;
			bank_r <= {NBANK{B_IDLE}};
			bcnt_r <= '0;
			all_idle_r <= 1'b1;
			need_init_r <= 1'b1;
			taken_r <= 1'b0;
			bad_r <= 1'b0;
		end else begin
			pwr_r <= pwr_nxt;
			stage_r <= stage_nxt;
			refs_r <= refs_nxt;
			nops_r <= nops_nxt;
			last_r <= last_nxt;
			cke_prev_r <= lnk.cke;
			gcnt_r <= gcnt_nxt;
			bank_r <= bank_nxt;
			bcnt_r <= bcnt_nxt;
			all_idle_r <= all_idle_nxt;
			need_init_r <= need_init_nxt;
			taken_r <= taken_nxt;
			bad_r <= bad;
		end
	end

	assign pwr_state = pwr_r;
	assign bank_state = bank_r;
	assign all_idle = all_idle_r;
	assign need_init = need_init_r;
	assign cmd_taken = taken_r;
	assign cmd_illegal = bad_r;
endmodule : sdram_state_dev

// ==== tb/sdram_cke_bank_state_control_asserts.sv ====
// checker for the command link between controller and memory ends
`timescale 1ns/100ps
`include "sdram_defines.svh"
module sdram_cke_bank_state_control_asserts (
	// clock and reset
	input logic clk,
	input logic rst_b,
	// link pins
	input logic cke,
	input logic cs_n,
	input logic ras_n,
	input logic cas_n,
	input logic we_n,
	input logic [1:0] ba,
	input logic a10,
	// memory state
	input sdram_pkg::pwr_t pwr_state,
	input sdram_pkg::bank_t [3:0] bank_state,
	input logic all_idle,
	input logic need_init,
	input logic cmd_taken,
	input logic cmd_illegal
);
	import sdram_pkg::*;
	logic [3:0] cmd;
	logic quiet;
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	assign quiet = cs_n | (cmd == `ENC_NOP);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	a_dpd_entry: assert property ($past(cke) && !cke && cmd == `ENC_BST |=> pwr_state == P_DPD)
		else $error("deep sleep not entered");
	a_dpd_exit_init: assert property (pwr_state == P_DPD && cke |=> pwr_state != P_DPD && need_init)
		else $error("deep sleep exit without reinit");
	a_pd_exit: assert property (pwr_state == P_PDN && cke && quiet |=> pwr_state == P_RUN)
		else $error("power-down exit late");
	a_suspend_exit: assert property (pwr_state == P_SUSP && cke |=> pwr_state == P_RUN)
		else $error("suspend exit late");
	a_pd_entry: assert property ($past(cke) && !cke && quiet && all_idle |=> pwr_state == P_PDN)
		else $error("power-down not entered");
	a_sref_entry: assert property ($past(cke) && !cke && cmd == `ENC_REF && all_idle |=>
		pwr_state == P_SREF)
		else $error("self refresh not entered");
	a_sref_exit_wait: assert property (pwr_state == P_SREF && cke |=> pwr_state == P_XSR [*2]
		##[1:6] all_idle)
		else $error("self refresh exit wait wrong");
	a_inhibit_quiet: assert property (cke && $past(cke) && cs_n |=> !cmd_illegal)
		else $error("deselect flagged");
	a_read_start: assert property (cke && $past(cke) && pwr_state == P_RUN && !need_init &&
		cmd == `ENC_RD && bank_state[ba] == B_ACT |=> cmd_taken &&
		bank_state[$past(ba)] == ($past(a10) ? B_RDA : B_RD))
		else $error("read not started");
	a_act_timing: assert property (cke && $past(cke) && pwr_state == P_RUN && !need_init &&
		cmd == `ENC_ACT && ba == 2'h0 && all_idle |=> bank_state[0] inside {B_ACTG, B_ACT}
		##[0:2] bank_state[0] == B_ACT)
		else $error("activate timing wrong");
	a_idle_precharge: assert property (cke && $past(cke) && pwr_state == P_RUN && !a10 &&
		cmd == `ENC_PRE && bank_state[ba] == B_IDLE |=> bank_state[$past(ba)] == B_IDLE
		&& !cmd_illegal)
		else $error("idle precharge changed bank");
	a_burst_stop: assert property (cke && $past(cke) && pwr_state == P_RUN && cmd == `ENC_BST
		&& bank_state[0] == B_RD |=> bank_state[0] == B_ACT)
		else $error("terminate did not end burst");

	c_dpd: cover property (pwr_state == P_DPD);
	c_susp: cover property (pwr_state == P_SUSP);
	c_xsr: cover property (pwr_state == P_XSR);
endmodule : sdram_cke_bank_state_control_asserts

// ==== tb/sdram_cke_bank_state_control_tb.sv ====
// testbench: controller and memory ends joined by one link
`timescale 1ns/100ps
`include "sdram_defines.svh"
module sdram_cke_bank_state_control_tb;
	import sdram_pkg::*;
	logic clk;
	logic rst_b;
	logic req_valid;
	cmd_t req_cmd;
	logic [1:0] req_ba;
	logic req_ap;
	logic req_ready;
	logic pd_hold;
	logic sr_hold;
	logic dpd_hold;
	logic init_done;
	pwr_t pwr_state;
	bank_t [3:0] bank_state;
	logic all_idle;
	logic need_init;
	logic cmd_taken;
	logic cmd_illegal;
	int fail_count = 0;
	int n_tests = 0;
	int cycles = 0;
	sdram_if lnk();
	sdram_ctl_host #(.PWRUP_CYC(20)) sdram_ctl_host_i (.clk(clk), .rst_b(rst_b), .lnk(lnk),
		.req_valid(req_valid), .req_cmd(req_cmd), .req_ba(req_ba), .req_ap(req_ap),
		.req_ready(req_ready), .pd_hold(pd_hold), .sr_hold(sr_hold), .dpd_hold(dpd_hold),
		.init_done(init_done));
	sdram_state_dev sdram_state_dev_i (.clk(clk), .rst_b(rst_b), .lnk(lnk),
		.pwr_state(pwr_state), .bank_state(bank_state), .all_idle(all_idle),
		.need_init(need_init), .cmd_taken(cmd_taken), .cmd_illegal(cmd_illegal));
	sdram_cke_bank_state_control_asserts sdram_cke_bank_state_control_asserts_i (.clk(clk),
		.rst_b(rst_b), .cke(lnk.cke), .cs_n(lnk.cs_n), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n),
		.we_n(lnk.we_n), .ba(lnk.ba), .a10(lnk.a10), .pwr_state(pwr_state),
		.bank_state(bank_state), .all_idle(all_idle), .need_init(need_init),
		.cmd_taken(cmd_taken), .cmd_illegal(cmd_illegal));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test

	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			fail_count++;
			end_of_test();
		end
	end

	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// request held until taken, returns after the memory registered it
	task automatic req(input cmd_t c, input logic [1:0] b, input logic ap);
		int k;
		k = 0;
		req_cmd = c;
		req_ba = b;
		req_ap = ap;
		req_valid = 1'b1;
		// ready is looked at where it has settled, then taken at the next rising edge
		while (req_ready !== 1'b1 && k < 200) begin
			k++;
			@(negedge clk);
		end
		@(posedge clk);
		@(negedge clk);
		req_valid = 1'b0;
		@(negedge clk);
		check(k < 200, 1'b1);
	endtask : req

	task automatic wait_pwr(input pwr_t exp, input int lim);
		int k;
		k = 0;
		while (pwr_state !== exp && k < lim) begin
			k++;
			@(negedge clk);
		end
		check(pwr_state, exp);
	endtask : wait_pwr

	task automatic wait_bank(input int b, input bank_t exp, input int lim);
		int k;
		k = 0;
		while (bank_state[b] !== exp && k < lim) begin
			k++;
			@(negedge clk);
		end
		check(bank_state[b], exp);
	endtask : wait_bank

	task automatic t_init();
		int k;
		k = 0;
		while (req_ready !== 1'b1 && k < 500) begin
			k++;
			@(negedge clk);
		end
		check(init_done, 1'b1);
		check(need_init, 1'b0);
		check(all_idle, 1'b1);
	endtask : t_init

	task automatic t_bank();
		req(C_ACT, 2'h0, 1'b0);
		check(cmd_taken, 1'b1);
		wait_bank(0, B_ACT, 4);
		req(C_ACT, 2'h1, 1'b0);
		check(cmd_taken, 1'b1);
		req(C_RD, 2'h0, 1'b0);
		check(bank_state[0], B_RD);
		// terminate sent to an idle bank still ends bank 0 burst
		req(C_BST, 2'h3, 1'b0);
		check(bank_state[0], B_ACT);
		req(C_WR, 2'h0, 1'b0);
		check(bank_state[0], B_WR);
		req(C_RD, 2'h0, 1'b0);
		check(bank_state[0], B_RD);
		req(C_WR, 2'h0, 1'b0);
		check(bank_state[0], B_WR);
		req(C_PRE, 2'h0, 1'b0);
		wait_bank(0, B_IDLE, 4);
		req(C_PRE, 2'h2, 1'b0);
		check(cmd_illegal, 1'b0);
		check(bank_state[2], B_IDLE);
		req(C_RD, 2'h1, 1'b1);
		check(bank_state[1], B_RDA);
		wait_bank(1, B_IDLE, 12);
	endtask : t_bank

	task automatic t_illegal();
		req(C_RD, 2'h2, 1'b0);
		check(cmd_illegal, 1'b1);
		check(bank_state[2], B_IDLE);
		req(C_BST, 2'h0, 1'b0);
		check(cmd_illegal, 1'b1);
	endtask : t_illegal

	task automatic t_pd();
		pd_hold = 1'b1;
		wait_pwr(P_PDN, 6);
		repeat (5) @(negedge clk);
		check(pwr_state, P_PDN);
		pd_hold = 1'b0;
		wait_pwr(P_RUN, 4);
		check(all_idle, 1'b1);
	endtask : t_pd

	task automatic t_susp();
		req(C_ACT, 2'h0, 1'b0);
		wait_bank(0, B_ACT, 4);
		req(C_RD, 2'h0, 1'b0);
		pd_hold = 1'b1;
		wait_pwr(P_SUSP, 4);
		repeat (6) @(negedge clk);
		check(bank_state[0], B_RD);
		pd_hold = 1'b0;
		wait_pwr(P_RUN, 4);
		wait_bank(0, B_ACT, 8);
		req(C_PRE, 2'h0, 1'b0);
		wait_bank(0, B_IDLE, 4);
	endtask : t_susp

	task automatic t_sref();
		sr_hold = 1'b1;
		wait_pwr(P_SREF, 6);
		repeat (4) @(negedge clk);
		sr_hold = 1'b0;
		wait_pwr(P_XSR, 4);
		wait_pwr(P_RUN, 8);
		check(all_idle, 1'b1);
	endtask : t_sref

	task automatic t_dpd();
		int k;
		k = 0;
		dpd_hold = 1'b1;
		wait_pwr(P_DPD, 6);
		check(init_done, 1'b0);
		dpd_hold = 1'b0;
		while (pwr_state === P_DPD && k < 5000) begin
			k++;
			@(negedge clk);
		end
		check(k >= `DPD_CYC - 2, 1'b1);
		check(need_init, 1'b1);
		t_init();
	endtask : t_dpd

	initial begin
		rst_b = 1'b0;
		req_valid = 1'b0;
		req_cmd = C_NOP;
		req_ba = 2'h0;
		req_ap = 1'b0;
		pd_hold = 1'b0;
		sr_hold = 1'b0;
		dpd_hold = 1'b0;
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		t_init();
		t_bank();
		t_illegal();
		t_pd();
		t_susp();
		t_sref();
		t_dpd();
		end_of_test();
	end
endmodule : sdram_cke_bank_state_control_tb
